// ==== src/gpc_axil_slave.sv ====
// axi4-lite slave: decodes port c offsets and aliases
// assumes synchronous active-low reset and one clock
`timescale 1ns/100ps
`include "gpc_defs.svh"
module gpc_axil_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [31:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  // write response
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // read
  input wire logic [31:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // core side
  gpc_wr_if.slave regs
);
  typedef struct packed {
    logic aw_have;
    logic [15:0] aw_addr;
    logic w_have;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gpc_slv_t;

  gpc_slv_t s_q;
  gpc_slv_t s_d;

  // ----------------------------------------
  // decode, used by both write and read paths
  // ----------------------------------------
  function automatic gpc_pkg::gpc_reg_t gpc_decode(input logic [15:0] a);
    logic [15:0] base;
    base = {a[15:4], 4'h0};
    if (a[1:0] != 2'b00) begin
      return gpc_pkg::GPC_REG_NONE;
    end
    if (base == `GPC_OFS_DIR) begin
      return gpc_pkg::GPC_REG_DIR; // [RULE1]
    end
    if (base == `GPC_OFS_LVL) begin
      return gpc_pkg::GPC_REG_LVL; // [RULE1]
    end
    if (base == `GPC_OFS_LAT) begin
      return gpc_pkg::GPC_REG_LAT; // [RULE2]
    end
    if (base == `GPC_OFS_ODC) begin
      return gpc_pkg::GPC_REG_ODC; // [RULE2]
    end
    return gpc_pkg::GPC_REG_NONE;
  endfunction : gpc_decode

  logic do_wr;
  gpc_pkg::gpc_reg_t wreg;
  gpc_pkg::gpc_reg_t rreg;

  always_comb begin
    wreg = gpc_decode(s_q.aw_addr);
    rreg = gpc_decode(s_axil_araddr[15:0]);
    do_wr = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    s_axil_awready = !s_q.aw_have;
    s_axil_wready = !s_q.w_have;
    s_axil_arready = !s_q.rvalid;
    s_axil_bvalid = s_q.bvalid;
    s_axil_bresp = s_q.bresp;
    s_axil_rvalid = s_q.rvalid;
    s_axil_rdata = s_q.rdata;
    s_axil_rresp = s_q.rresp;
    regs.wr_en = do_wr && (wreg != gpc_pkg::GPC_REG_NONE);
    regs.wr_reg = wreg;
    // aliases are bits 3:2; the enum order matches the sub-offset codes
    regs.wr_op = gpc_pkg::gpc_op_t'(s_q.aw_addr[3:2]); // [RULE8]
    // upper byte lanes carry only unimplemented bits, so strobes 3:2 are moot
    regs.wr_data = s_q.w_data & {{8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
    regs.rd_reg = rreg;
    s_d = s_q;
    if (s_axil_awvalid && !s_q.aw_have) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axil_awaddr[15:0];
    end
    if (s_axil_wvalid && !s_q.w_have) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axil_wdata[15:0];
      s_d.w_strb = s_axil_wstrb[1:0];
    end
    if (do_wr) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (wreg == gpc_pkg::GPC_REG_NONE) ? `GPC_RESP_SLVERR : `GPC_RESP_OKAY;
    end
    if (s_q.bvalid && s_axil_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axil_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = {`GPC_ZERO16, regs.rd_data}; // [RULE3]
      // alias addresses are write only and read back zero
      if (rreg == gpc_pkg::GPC_REG_NONE) begin
        s_d.rresp = `GPC_RESP_SLVERR;
        s_d.rdata = 32'h0000_0000;
      end else begin
        s_d.rresp = `GPC_RESP_OKAY;
        if (s_axil_araddr[3:2] != `GPC_SUB_BASE) begin
          s_d.rdata = 32'h0000_0000;
        end
      end
    end else if (s_q.rvalid && s_axil_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (!aresetn) begin
      s_d = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end
endmodule : gpc_axil_slave

// ==== common/gpc_defs.svh ====
// constants for the port c register bank
// assumes inclusion by bare name from common/
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define GPC_OFS_DIR 16'h6080
`define GPC_OFS_LVL 16'h6090
`define GPC_OFS_LAT 16'h60A0
`define GPC_OFS_ODC 16'h60B0
`define GPC_ADDR_W 16
// alias sub-offsets, address bits 3:2
`define GPC_SUB_BASE 2'h0
`define GPC_SUB_CLR 2'h1
`define GPC_SUB_SET 2'h2
`define GPC_SUB_INV 2'h3
// ----------------------------------------
// pin masks and reset values
// ----------------------------------------
`define GPC_MASK_LARGE 16'hF01E
`define GPC_MASK_SMALL 16'hF000
`define GPC_DIR_RST_LARGE 16'hF01E
`define GPC_DIR_RST_SMALL 16'hF000
`define GPC_ODC_RST 16'h0000
`define GPC_LAT_RST 16'h0000
`define GPC_ZERO16 16'h0000
`define GPC_RESP_OKAY 2'b00
`define GPC_RESP_SLVERR 2'b10

`endif

// ==== common/gpc_pkg.sv ====
// types for the port c register bank
// assumes gpc_defs.svh is on the include path
package gpc_pkg;
  typedef enum logic [2:0] {
    GPC_REG_DIR,
    GPC_REG_LVL,
    GPC_REG_LAT,
    GPC_REG_ODC,
    GPC_REG_NONE
  } gpc_reg_t;

  typedef enum logic [1:0] {
    GPC_OP_WRITE,
    GPC_OP_CLR,
    GPC_OP_SET,
    GPC_OP_INV
  } gpc_op_t;
endpackage : gpc_pkg

// ==== common/gpc_wr_if.sv ====
// register write request carrier between bus slave and core
// assumes one clock domain
`timescale 1ns/100ps
interface gpc_wr_if;
  logic wr_en;
  gpc_pkg::gpc_reg_t wr_reg;
  gpc_pkg::gpc_op_t wr_op;
  logic [15:0] wr_data;
  gpc_pkg::gpc_reg_t rd_reg;
  logic [15:0] rd_data;
  modport slave (output wr_en, output wr_reg, output wr_op, output wr_data, output rd_reg, input rd_data);
  modport core (input wr_en, input wr_reg, input wr_op, input wr_data, input rd_reg, output rd_data);
endinterface : gpc_wr_if

// ==== src/gpc_pin_ctrl.sv ====
// pin pad control: direction, latch and open-drain to pad enables
// assumes pads are resolved outside from out and oe
`timescale 1ns/100ps
module gpc_pin_ctrl (
  // register state
  input wire logic [15:0] dir,
  input wire logic [15:0] lat,
  input wire logic [15:0] odc,
  input wire logic [15:0] mask,
  // pads
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe
);
  always_comb begin
    // direction bit high means input; open drain only drives low
    pin_out = lat & mask;
    pin_oe = ~dir & mask & ~(odc & lat);
  end
endmodule : gpc_pin_ctrl

// ==== src/gpc_port.sv ====
// port c register bank top: axi4-lite registers and pin pads
// assumes pin inputs synchronous to aclk, reset synchronous active low
//
// Summary of operation
// [RULE1] direction at 0x6080, pin level at 0x6090.
// [RULE2] output latch at 0x60A0, open-drain select at 0x60B0, 32 bits.
// [RULE3] bits 31:16 and unassigned pins ignore writes and read zero.
// [RULE4] large variant: pins 15:12 and 4:1, direction resets to F01E.
// [RULE5] small variant: pins 15:12 only, direction resets to F000.
// [RULE6] level and latch pin bits undefined after reset, upper half zero.
// [RULE7] open-drain select resets to zero on every reset.
// [RULE8] clear, set, invert aliases at base plus 0x4, 0x8, 0xC.
// [RULE9] alias writes clear, set or toggle only the one bits written.
`timescale 1ns/100ps
`include "gpc_defs.svh"
module gpc_port #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [31:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  // axi4-lite write response
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // axi4-lite read
  input wire logic [31:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // port pins, bit n is pin n
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] lat;
    logic [15:0] odc;
    logic [15:0] lvl;
  } gpc_state_t;

  gpc_state_t r_q;
  gpc_state_t r_d;

  localparam logic [15:0] PIN_MASK = LARGE_VARIANT ? `GPC_MASK_LARGE : `GPC_MASK_SMALL; // [RULE4] [RULE5]
  localparam logic [15:0] DIR_RST = LARGE_VARIANT ? `GPC_DIR_RST_LARGE : `GPC_DIR_RST_SMALL; // [RULE4] [RULE5]

  gpc_wr_if regs ();

  gpc_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .regs(regs)
  );

  gpc_pin_ctrl u_pins (
    .dir(r_q.dir),
    .lat(r_q.lat),
    .odc(r_q.odc),
    .mask(PIN_MASK),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  // ----------------------------------------
  // alias arithmetic
  // ----------------------------------------
  function automatic logic [15:0] gpc_apply(input logic [15:0] cur, input gpc_pkg::gpc_op_t op,
                                             input logic [15:0] data, input logic [15:0] mask);
    logic [15:0] nxt;
    unique case (op)
      gpc_pkg::GPC_OP_WRITE: nxt = data;
      gpc_pkg::GPC_OP_CLR: nxt = cur & ~data; // [RULE9]
      gpc_pkg::GPC_OP_SET: nxt = cur | data; // [RULE9]
      gpc_pkg::GPC_OP_INV: nxt = cur ^ data; // [RULE9]
    endcase
    return nxt & mask; // [RULE3]
  endfunction : gpc_apply

  always_comb begin
    r_d = r_q;
    // level register samples the pads every cycle out of reset; it is the pin state
    r_d.lvl = pin_in & PIN_MASK; // [RULE3]
    if (regs.wr_en) begin
      unique case (regs.wr_reg)
        gpc_pkg::GPC_REG_DIR: r_d.dir = gpc_apply(r_q.dir, regs.wr_op, regs.wr_data, PIN_MASK);
        // a write to the level register lands in the latch, as ports usually do
        gpc_pkg::GPC_REG_LVL: r_d.lat = gpc_apply(r_q.lat, regs.wr_op, regs.wr_data, PIN_MASK);
        gpc_pkg::GPC_REG_LAT: r_d.lat = gpc_apply(r_q.lat, regs.wr_op, regs.wr_data, PIN_MASK);
        gpc_pkg::GPC_REG_ODC: r_d.odc = gpc_apply(r_q.odc, regs.wr_op, regs.wr_data, PIN_MASK);
        default: r_d = r_d;
      endcase
    end
    unique case (regs.rd_reg)
      gpc_pkg::GPC_REG_DIR: regs.rd_data = r_q.dir;
      gpc_pkg::GPC_REG_LVL: regs.rd_data = r_q.lvl;
      gpc_pkg::GPC_REG_LAT: regs.rd_data = r_q.lat;
      gpc_pkg::GPC_REG_ODC: regs.rd_data = r_q.odc;
      default: regs.rd_data = `GPC_ZERO16;
    endcase
    if (!aresetn) begin
      r_d.dir = DIR_RST; // [RULE4] [RULE5]
      r_d.odc = `GPC_ODC_RST; // [RULE7]
      // level and latch are undefined by spec; zero chosen, upper half zero anyway
      r_d.lat = `GPC_LAT_RST; // [RULE6]
      r_d.lvl = `GPC_ZERO16; // [RULE6]
    end
  end

  always_ff @(posedge aclk) begin
    r_q <= r_d;
  end
endmodule : gpc_port

// ==== verif/gpc_port_asserts.sv ====
// checker for the port c register bank
// assumes a bind onto gpc_port and one clock domain
`timescale 1ns/100ps
`include "gpc_defs.svh"
module gpc_port_asserts #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // read channels
  input wire logic [31:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid,
  // write response
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // pins
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe
);
  localparam logic [15:0] MASK = LARGE_VARIANT ? `GPC_MASK_LARGE : `GPC_MASK_SMALL;
  logic ar_hs;
  logic [15:0] ra;
  assign ar_hs = s_axil_arvalid && s_axil_arready;
  assign ra = s_axil_araddr[15:0];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_dir_dec;
    ar_hs && (ra == `GPC_OFS_DIR || ra == `GPC_OFS_LVL) |=> s_axil_rvalid && s_axil_rresp == `GPC_RESP_OKAY;
  endproperty
  property p_lat_dec;
    ar_hs && (ra == `GPC_OFS_LAT || ra == `GPC_OFS_ODC) |=> s_axil_rvalid && s_axil_rresp == `GPC_RESP_OKAY;
  endproperty
  // aliases are write-only, so a read sees zero
  property p_alias_rd;
    ar_hs && ra[15:6] == 10'h182 && ra[3:2] != 2'h0 && ra[1:0] == 2'h0 |=> s_axil_rvalid && s_axil_rdata == '0;
  endproperty
  property p_unmap;
    ar_hs && ra[15:6] != 10'h182 |=> s_axil_rresp == `GPC_RESP_SLVERR && s_axil_rdata == '0;
  endproperty
  property p_upper;
    s_axil_rvalid |-> s_axil_rdata[31:16] == `GPC_ZERO16;
  endproperty
  property p_unimpl;
    s_axil_rvalid |-> (s_axil_rdata[15:0] & ~MASK) == `GPC_ZERO16;
  endproperty
  property p_pins;
    ((pin_out | pin_oe) & ~MASK) == `GPC_ZERO16;
  endproperty
  property p_rst;
    $rose(aresetn) |-> pin_oe == `GPC_ZERO16 ##1 pin_oe == `GPC_ZERO16;
  endproperty
  a_dir_dec: assert property (p_dir_dec) else $error("direction or level read not decoded");
  a_lat_dec: assert property (p_lat_dec) else $error("latch or open drain read not decoded");
  a_alias_rd: assert property (p_alias_rd) else $error("alias read not zero");
  a_unmap: assert property (p_unmap) else $error("unmapped read accepted");
  a_upper: assert property (p_upper) else $error("upper half not zero");
  a_unimpl: assert property (p_unimpl) else $error("unassigned bit reads one");
  a_pins: assert property (p_pins) else $error("unassigned pin driven");
  a_rst: assert property (p_rst) else $error("pin enabled after reset");
  c_lvl: cover property (ar_hs && ra == `GPC_OFS_LVL);
  c_wr: cover property (s_axil_bvalid && s_axil_bready);
  c_rst: cover property ($rose(aresetn));
endmodule : gpc_port_asserts

// ==== verif/tb_top.sv ====
// testbench for the port c register bank
// assumes the large variant and an axi4-lite master driven here
`timescale 1ns/100ps
`include "gpc_defs.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
  typedef struct packed {logic w; logic [15:0] a; logic [31:0] d; logic [1:0] r;} gpc_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
  logic [31:0] s_axil_awaddr = '0, s_axil_wdata = '0, s_axil_araddr = '0;
  logic [3:0] s_axil_wstrb = 4'hF;
  logic [15:0] pin_in = 16'hA5A5;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp, r;
  logic [31:0] s_axil_rdata, q;
  logic [15:0] pin_out, pin_oe;
  int bad_count = 0, total_checks = 0;
  // write rows carry data, read rows the expected word
  gpc_row_t rows [23] = '{
    '{1'b1, 16'h6080, 32'hFFFF_FFFF, 2'h0}, '{1'b0, 16'h6080, 32'h0000_F01E, 2'h0},
    '{1'b1, 16'h6084, 32'h0000_0006, 2'h0}, '{1'b0, 16'h6080, 32'h0000_F018, 2'h0},
    '{1'b1, 16'h6088, 32'h0000_0003, 2'h0}, '{1'b0, 16'h6080, 32'h0000_F01A, 2'h0},
    '{1'b1, 16'h608C, 32'h0000_F00F, 2'h0}, '{1'b0, 16'h6080, 32'h0000_0014, 2'h0},
    '{1'b1, 16'h60A0, 32'hFFFF_0012, 2'h0}, '{1'b0, 16'h60A0, 32'h0000_0012, 2'h0},
    '{1'b1, 16'h60AC, 32'h0000_0006, 2'h0}, '{1'b0, 16'h60A0, 32'h0000_0014, 2'h0},
    '{1'b1, 16'h6098, 32'h0000_1000, 2'h0}, '{1'b0, 16'h60A0, 32'h0000_1014, 2'h0},
    '{1'b1, 16'h60B8, 32'hFFFF_FFFF, 2'h0}, '{1'b0, 16'h60B0, 32'h0000_F01E, 2'h0},
    '{1'b1, 16'h60B4, 32'h0000_0FFF, 2'h0}, '{1'b0, 16'h60B0, 32'h0000_F000, 2'h0},
    '{1'b0, 16'h6084, 32'h0000_0000, 2'h0}, '{1'b0, 16'h6090, 32'h0000_A004, 2'h0},
    '{1'b1, 16'h6000, 32'hFFFF_FFFF, 2'h2}, '{1'b0, 16'h6000, 32'h0000_0000, 2'h2},
    '{1'b0, 16'h6080, 32'h0000_0014, 2'h0}};
  gpc_port #(.LARGE_VARIANT(1'b1)) u_gpc_port (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid,
    .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
    .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
    .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .pin_in, .pin_out, .pin_oe);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // one write or one read; each channel released at its own handshake
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    logic aw_t, w_t, ar_t, done;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_araddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= w;
    s_axil_wvalid <= w;
    s_axil_bready <= w;
    s_axil_arvalid <= !w;
    s_axil_rready <= !w;
    for (n = 0; n < 64; n++) begin
      // sample mid-cycle: readies and answers are settled there and stand through the next edge,
      // which avoids racing the slave's own update at the rising edge
      @(negedge aclk);
      aw_t = s_axil_awvalid && s_axil_awready;
      w_t = s_axil_wvalid && s_axil_wready;
      ar_t = s_axil_arvalid && s_axil_arready;
      done = w ? s_axil_bvalid : s_axil_rvalid;
      q = s_axil_rdata;
      r = w ? s_axil_bresp : s_axil_rresp;
      @(posedge aclk);
      if (aw_t) s_axil_awvalid <= 1'b0;
      if (w_t) s_axil_wvalid <= 1'b0;
      if (ar_t) s_axil_arvalid <= 1'b0;
      if (done) break;
    end
    s_axil_bready <= 1'b0;
    s_axil_rready <= 1'b0;
    if (n == 64) begin
      bad_count++;
      stop_test();
    end
  endtask : xfer
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 23; i++) begin
      xfer(rows[i].w, {16'h0000, rows[i].a}, rows[i].d);
      `CHK("response", rows[i].r, r)
      if (!rows[i].w) `CHK("read data", rows[i].d, q)
    end
    $display("register table test done");
    `CHK("pin out", 16'h1014, pin_out)
    `CHK("pin enable", 16'hE00A, pin_oe)
    $display("pin test done");
    // a second reset in mid-run must restore direction and open drain
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(1'b0, 32'h0000_6080, 32'h0000_0000);
    `CHK("direction reset", 32'h0000_F01E, q)
    xfer(1'b0, 32'h0000_60B0, 32'h0000_0000);
    `CHK("open drain reset", 32'h0000_0000, q)
    xfer(1'b0, 32'h0000_60A0, 32'h0000_0000);
    `CHK("latch upper half", 16'h0000, q[31:16])
    $display("reset test done");
    stop_test();
  end
endmodule : tb_top
bind gpc_port gpc_port_asserts #(.LARGE_VARIANT(LARGE_VARIANT)) u_gpc_port_asserts (.aclk, .aresetn,
  .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
  .s_axil_bvalid, .s_axil_bready, .pin_out, .pin_oe);
